// ---- hw/asmc_host.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Each read or write cycle lasts at least the access time.
// - Select held low 50/60 ns before each write ends.
// - Address valid 50/60 ns before write end, stable throughout the write.
// - Write data valid 25/30 ns before the write ends.
// - Controller never drives the bus while the device may drive it.
// - With oe low, write pulse covers data-valid plus turn-off time.
// - Select is deselected no later than the start of data retention.
module asmc_host #(
	parameter bit FAST_GRADE = 1'b1,
	parameter int RECOVERY_CYCLES =
		asmc_pkg::RECOVERY_MS * (asmc_pkg::NS_PER_MS / asmc_pkg::CLK_PERIOD_NS)
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic req_valid_i,
	input wire asmc_pkg::asmc_req_t req_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [asmc_pkg::DATA_W-1:0] rd_data_o,
	output logic wr_done_o,
	input wire logic retain_req_i,
	output logic retain_ack_o,
	output asmc_pkg::asmc_pins_t pins_o,
	input wire logic [asmc_pkg::DATA_W-1:0] byte_data_lines_i,
	output logic [asmc_pkg::DATA_W-1:0] byte_data_lines_o,
	output logic byte_data_lines_oe_o
);

	localparam int ACCESS_NS = FAST_GRADE ? asmc_pkg::FAST_ACCESS_NS : asmc_pkg::SLOW_ACCESS_NS;
	localparam int CW_NS = FAST_GRADE ? asmc_pkg::FAST_SELECT_TO_WRITE_END_NS
		: asmc_pkg::SLOW_SELECT_TO_WRITE_END_NS;
	localparam int DW_NS = FAST_GRADE ? asmc_pkg::FAST_DATA_VALID_BEFORE_WRITE_END_NS
		: asmc_pkg::SLOW_DATA_VALID_BEFORE_WRITE_END_NS;
	localparam int WHZ_NS = FAST_GRADE ? asmc_pkg::FAST_WRITE_TO_OUTPUT_FLOAT_NS
		: asmc_pkg::SLOW_WRITE_TO_OUTPUT_FLOAT_NS;
	localparam int HZ_NS = FAST_GRADE ? asmc_pkg::FAST_DESELECT_TO_OUTPUT_FLOAT_NS
		: asmc_pkg::SLOW_DESELECT_TO_OUTPUT_FLOAT_NS;
	// One extra cycle covers the sampling delay of the synchronous data input.
	localparam int READ_CYC = asmc_pkg::ceil_cycles(ACCESS_NS) + 1;
	localparam int CW_CYC = asmc_pkg::ceil_cycles(CW_NS);
	localparam int WP_MIN_CYC = asmc_pkg::ceil_cycles(DW_NS + WHZ_NS);
	localparam int CYCLE_CYC = asmc_pkg::ceil_cycles(ACCESS_NS);
	localparam int WRITE_CYC0 = (CW_CYC > WP_MIN_CYC) ? CW_CYC : WP_MIN_CYC;
	localparam int WRITE_CYC = (WRITE_CYC0 > CYCLE_CYC) ? WRITE_CYC0 : CYCLE_CYC;
	localparam int TURN_CYC = asmc_pkg::ceil_cycles(HZ_NS);
	localparam int CNT_W = $clog2(RECOVERY_CYCLES + 1);

	initial
	begin
		if (RECOVERY_CYCLES < 1)
			$error("RECOVERY_CYCLES must be at least one");
	end

	asmc_pkg::asmc_state_t state;
	logic [CNT_W-1:0] count;
	logic was_read;

	assign req_ready_o = (state == asmc_pkg::ST_IDLE) && !retain_req_i;

	// Sequencer. Reset and retention exit both pass through recovery before access.
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= asmc_pkg::ST_RECOVER;
			count <= '0;
			was_read <= 1'b0;
		end
		else
		begin
			unique case (state)
				asmc_pkg::ST_RECOVER:
				begin
					if (count == CNT_W'(RECOVERY_CYCLES - 1))
					begin
						state <= asmc_pkg::ST_IDLE;
						count <= '0;
					end
					else
						count <= count + 1'b1;
				end
				asmc_pkg::ST_IDLE:
				begin
					count <= '0;
					if (retain_req_i)
						state <= asmc_pkg::ST_RETAIN;
					else if (req_valid_i)
						state <= req_i.write ? asmc_pkg::ST_WRITE : asmc_pkg::ST_READ;
				end
				asmc_pkg::ST_READ:
				begin
					if (count == CNT_W'(READ_CYC - 1))
					begin
						state <= asmc_pkg::ST_TURN;
						count <= '0;
						was_read <= 1'b1;
					end
					else
						count <= count + 1'b1;
				end
				asmc_pkg::ST_WRITE:
				begin
					if (count == CNT_W'(WRITE_CYC - 1))
					begin
						state <= asmc_pkg::ST_TURN;
						count <= '0;
						was_read <= 1'b0;
					end
					else
						count <= count + 1'b1;
				end
				asmc_pkg::ST_TURN:
				begin
					// Deselected gap lets the device float before anyone drives again.
					if (count == CNT_W'(TURN_CYC - 1))
					begin
						state <= asmc_pkg::ST_IDLE;
						count <= '0;
					end
					else
						count <= count + 1'b1;
				end
				asmc_pkg::ST_RETAIN:
				begin
					count <= '0;
					if (!retain_req_i)
						state <= asmc_pkg::ST_RECOVER;
				end
				default:
					state <= asmc_pkg::ST_RECOVER;
			endcase
		end
	end

	// Pin drive: address latched at acceptance and held stable through the cycle.
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pins_o.addr <= '0;
			pins_o.cs_n <= 1'b1;
			pins_o.oe_n <= 1'b1;
			pins_o.we_n <= 1'b1;
			byte_data_lines_o <= '0;
			byte_data_lines_oe_o <= 1'b0;
		end
		else if (state == asmc_pkg::ST_IDLE && req_valid_i && !retain_req_i)
		begin
			pins_o.addr <= req_i.addr;
			// For a write, select and write enable fall together, so the device never drives.
			pins_o.cs_n <= 1'b0;
			pins_o.we_n <= !req_i.write;
			pins_o.oe_n <= req_i.write;
			byte_data_lines_o <= req_i.wdata;
			byte_data_lines_oe_o <= req_i.write;
		end
		else if ((state == asmc_pkg::ST_READ && count == CNT_W'(READ_CYC - 1)) ||
			(state == asmc_pkg::ST_WRITE && count == CNT_W'(WRITE_CYC - 1)))
		begin
			// Both strobes rise together; data stays one more cycle for hold.
			pins_o.cs_n <= 1'b1;
			pins_o.we_n <= 1'b1;
			pins_o.oe_n <= 1'b1;
		end
		else if (state == asmc_pkg::ST_TURN)
			byte_data_lines_oe_o <= 1'b0;
	end

	// Answers to the user side.
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
			wr_done_o <= 1'b0;
			retain_ack_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= state == asmc_pkg::ST_READ && count == CNT_W'(READ_CYC - 1);
			wr_done_o <= state == asmc_pkg::ST_WRITE && count == CNT_W'(WRITE_CYC - 1);
			if (state == asmc_pkg::ST_READ && count == CNT_W'(READ_CYC - 1))
				rd_data_o <= byte_data_lines_i;
			retain_ack_o <= state == asmc_pkg::ST_RETAIN;
		end
	end

endmodule

// ---- hw/asmc_pkg.sv ----
package asmc_pkg;

	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;

	// Fast grade timing in ns.
	localparam int FAST_ACCESS_NS = 55;
	localparam int FAST_SELECT_TO_WRITE_END_NS = 50;
	localparam int FAST_DATA_VALID_BEFORE_WRITE_END_NS = 25;
	localparam int FAST_WRITE_TO_OUTPUT_FLOAT_NS = 20;
	localparam int FAST_DESELECT_TO_OUTPUT_FLOAT_NS = 20;
	// Slow grade timing in ns.
	localparam int SLOW_ACCESS_NS = 70;
	localparam int SLOW_SELECT_TO_WRITE_END_NS = 60;
	localparam int SLOW_DATA_VALID_BEFORE_WRITE_END_NS = 30;
	localparam int SLOW_WRITE_TO_OUTPUT_FLOAT_NS = 25;
	localparam int SLOW_DESELECT_TO_OUTPUT_FLOAT_NS = 25;

	localparam int RECOVERY_MS = 5;
	localparam int NS_PER_MS = 1000000;

	function automatic int ceil_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asmc_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic cs_n;
		logic oe_n;
		logic we_n;
	} asmc_pins_t;

	typedef enum logic [2:0] {
		ST_RECOVER = 3'b000,
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b011,
		ST_TURN = 3'b100,
		ST_RETAIN = 3'b101
	} asmc_state_t;

endpackage

// ---- verification/asmc_sram.sv ----
`timescale 1ns/10ps
module asmc_sram (
	input wire asmc_pkg::asmc_pins_t pins_i,
	input wire logic [7:0] bus_i,
	output logic [7:0] q_o,
	output logic drv_o
);
	logic [7:0] mem [int];
	wire wr = !pins_i.cs_n && !pins_i.we_n;
	assign drv_o = !pins_i.cs_n && pins_i.we_n && !pins_i.oe_n;
	always_comb
		q_o = mem.exists(pins_i.addr) ? mem[pins_i.addr] : 8'h00;
	// Capture on the earlier rising strobe, with the data present then.
	always @(negedge wr) mem[pins_i.addr] = bus_i;
endmodule

// ---- verification/asmc_host_chk.sv ----
`timescale 1ns/10ps
module asmc_host_chk (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic req_valid_i,
	input wire asmc_pkg::asmc_req_t req_i,
	input wire logic req_ready_o,
	input wire logic rd_valid_o,
	input wire logic [7:0] rd_data_o,
	input wire logic wr_done_o,
	input wire logic retain_req_i,
	input wire logic retain_ack_o,
	input wire asmc_pkg::asmc_pins_t pins_o,
	input wire logic [7:0] byte_data_lines_i,
	input wire logic [7:0] byte_data_lines_o,
	input wire logic byte_data_lines_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire take = req_valid_i && req_ready_o;
	// Strobes fall at the taking edge, so seven selected samples precede a read's release and six a write's.
	sequence rd_hold;
		(!pins_o.cs_n && !pins_o.oe_n && pins_o.we_n) [*7];
	endsequence
	sequence wr_hold;
		(!pins_o.cs_n && !pins_o.we_n && pins_o.oe_n) [*6];
	endsequence
	read_cycle_a: assert property (take && !req_i.write |=> rd_hold ##1 rd_valid_o && pins_o.cs_n)
		else $error("read cycle shape wrong");
	write_cycle_a: assert property (take && req_i.write |=> wr_hold ##1 wr_done_o && pins_o.we_n)
		else $error("write cycle shape wrong");
	rd_capture_a: assert property (rd_valid_o |-> rd_data_o == $past(byte_data_lines_i))
		else $error("read byte not taken from bus");
	addr_steady_a: assert property (!pins_o.cs_n && $past(!pins_o.cs_n) |-> $stable(pins_o.addr))
		else $error("address moved while selected");
	strobe_pair_a: assert property ($changed(pins_o.we_n) |-> $changed(pins_o.cs_n))
		else $error("write strobes not paired");
	no_clash_a: assert property (byte_data_lines_oe_o |-> pins_o.oe_n)
		else $error("host drives while device may");
	wdata_held_a: assert property (!pins_o.we_n |->
		byte_data_lines_oe_o && ($past(pins_o.we_n) || $stable(byte_data_lines_o)))
		else $error("write data not held");
	retain_sel_a: assert property (retain_ack_o |-> pins_o.cs_n && !req_ready_o)
		else $error("selected during retention");
	recover_a: assert property ($fell(retain_ack_o) |-> !req_ready_o [*8])
		else $error("access before recovery");
endmodule
bind asmc_host asmc_host_chk chk (.*);

// ---- verification/test_asmc_host.sv ----
`timescale 1ns/10ps
module test_asmc_host;
	logic clk_i = 0, reset_i = 1, req_valid_i = 0, retain_req_i = 0;
	asmc_pkg::asmc_req_t req_i = '0;
	logic req_ready_o, rd_valid_o, wr_done_o, retain_ack_o, byte_data_lines_oe_o, drv;
	logic [7:0] rd_data_o, byte_data_lines_o, q, flt = 8'h00;
	asmc_pkg::asmc_pins_t pins_o;
	// A released bus toggles each cycle so stale data can never match.
	wire [7:0] bus = byte_data_lines_oe_o ? byte_data_lines_o : drv ? q : flt;
	int num_errors = 0, n_compared = 0;
	asmc_host #(.RECOVERY_CYCLES(20)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_done_o(wr_done_o),
		.retain_req_i(retain_req_i), .retain_ack_o(retain_ack_o), .pins_o(pins_o),
		.byte_data_lines_i(bus), .byte_data_lines_o(byte_data_lines_o),
		.byte_data_lines_oe_o(byte_data_lines_oe_o));
	asmc_sram mem (.pins_i(pins_o), .bus_i(bus), .q_o(q), .drv_o(drv));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) flt <= ~bus;
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task op(input logic w, input logic [18:0] a, input logic [7:0] d);
		int n;
		@(negedge clk_i);
		req_i = '{w, a, d};
		req_valid_i = 1;
		for (n = 0; req_ready_o !== 1'b1 && n < 100; n++) @(negedge clk_i);
		@(negedge clk_i);
		req_valid_i = 0;
		for (n = 0; (w ? wr_done_o : rd_valid_o) !== 1'b1 && n < 20; n++) @(negedge clk_i);
		cmp({7'h00, w ? wr_done_o : rd_valid_o}, 8'h01);
		if (!w)
			cmp(rd_data_o, d);
	endtask
	task t_rw;
		op(1, 19'h00000, 8'ha5);
		op(1, 19'h7ffff, 8'h5a);
		op(1, 19'h55555, 8'h3c);
		op(1, 19'h00000, 8'hc3);
		op(0, 19'h7ffff, 8'h5a);
		op(0, 19'h00000, 8'hc3);
		op(0, 19'h55555, 8'h3c);
	endtask
	task t_retain;
		int n;
		@(negedge clk_i);
		retain_req_i = 1;
		repeat (3) @(negedge clk_i);
		cmp({6'h00, retain_ack_o, pins_o.cs_n}, 8'h03);
		cmp({7'h00, req_ready_o}, 8'h00);
		retain_req_i = 0;
		for (n = 0; req_ready_o !== 1'b1 && n < 60; n++) @(negedge clk_i);
		cmp({7'h00, n >= 19 && n < 60}, 8'h01);
		op(0, 19'h55555, 8'h3c);
	endtask
	task stop_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		num_errors++;
		stop_test;
	end
	initial
	begin
		repeat (8) @(negedge clk_i);
		reset_i = 0;
		t_rw;
		t_retain;
		stop_test;
	end
endmodule
